// ### verilog/limit_regs_pkg.sv
// Constants, register map and carrier types of the limit status and fault bank
// Assumes one 10 MHz clock shared with the serial front end and the converter logic
package limit_regs_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_ALERT_EN = 8'h01;
  localparam logic [7:0] OFF_STATUS = 8'h02;
  localparam logic [7:0] OFF_FAULT = 8'h03;
  localparam logic [7:0] OFF_POWER_MEAS = 8'h05;
  localparam logic [7:0] OFF_POWER_MAX_THR = 8'h0e;
  localparam logic [7:0] OFF_POWER_MIN_THR = 8'h11;
  localparam logic [7:0] OFF_SENSE_MEAS = 8'h14;
  localparam logic [7:0] OFF_SENSE_MAX_THR = 8'h1a;
  localparam logic [7:0] OFF_SENSE_MIN_THR = 8'h1c;
  localparam logic [7:0] OFF_VOLT_MEAS = 8'h1e;
  localparam logic [7:0] OFF_VOLT_MAX_THR = 8'h24;
  localparam logic [7:0] OFF_VOLT_MIN_THR = 8'h26;
  localparam logic [7:0] OFF_AUX_MEAS = 8'h28;
  localparam logic [7:0] OFF_AUX_MAX_THR = 8'h2e;
  localparam logic [7:0] OFF_AUX_MIN_THR = 8'h30;
  localparam logic [7:0] OFF_LAST = 8'h31;
  localparam int MEM_DEPTH = 50;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CTRL_TEST_MODE_BIT = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h05;
  localparam logic [7:0] ALERT_EN_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] LOW_BYTE_KEEP = 8'hf0;
  localparam logic [7:0] MAX_THR_RESET = 8'hff;

  // Quantity indices within the update vector
  localparam int Q_POWER = 3;
  localparam int Q_SENSE = 2;
  localparam int Q_VOLT = 1;
  localparam int Q_AUX = 0;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } result_s;

endpackage

// ### verilog/limit_status_fault_regs.sv
// Limit status and fault register bank of a power monitor
// Assumes a byte-wide register port from the serial front end and result strobes
// from the converter logic, all on the same clock
`timescale 1ns/100ps
`default_nettype none

module limit_status_fault_regs
  import limit_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire reg_req_s regReq,
  output logic [7:0] rdData,
  output logic rdValid,
  input wire result_s powerResult,
  input wire result_s senseResult,
  input wire result_s inputVoltageChannel,
  input wire result_s auxiliaryInput,
  output logic testMode,
  output logic alert
);

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic logic [23:0] val12(input logic [7:0] hi, input logic [7:0] lo);
    val12 = {12'h000, hi, lo[7:4]};
  endfunction

  function automatic logic [1:0] compare(input logic [23:0] v, input logic [23:0] mx,
                                         input logic [23:0] mn);
    compare = {v > mx, v < mn};
  endfunction

  function automatic logic isLowByte(input logic [7:0] a);
    isLowByte = (a == OFF_SENSE_MEAS + 8'h01) || (a == OFF_SENSE_MAX_THR + 8'h01) ||
                (a == OFF_SENSE_MIN_THR + 8'h01) || (a == OFF_VOLT_MEAS + 8'h01) ||
                (a == OFF_VOLT_MAX_THR + 8'h01) || (a == OFF_VOLT_MIN_THR + 8'h01) ||
                (a == OFF_AUX_MEAS + 8'h01) || (a == OFF_AUX_MAX_THR + 8'h01) ||
                (a == OFF_AUX_MIN_THR + 8'h01);
  endfunction

  function automatic logic isMeas(input logic [7:0] a);
    isMeas = (a >= OFF_POWER_MEAS && a <= OFF_POWER_MEAS + 8'h02) ||
             (a >= OFF_SENSE_MEAS && a <= OFF_SENSE_MEAS + 8'h01) ||
             (a >= OFF_VOLT_MEAS && a <= OFF_VOLT_MEAS + 8'h01) ||
             (a >= OFF_AUX_MEAS && a <= OFF_AUX_MEAS + 8'h01);
  endfunction

  function automatic logic isThr(input logic [7:0] a);
    isThr = (a >= OFF_POWER_MAX_THR && a <= OFF_POWER_MIN_THR + 8'h02) ||
            (a >= OFF_SENSE_MAX_THR && a <= OFF_SENSE_MIN_THR + 8'h01) ||
            (a >= OFF_VOLT_MAX_THR && a <= OFF_VOLT_MIN_THR + 8'h01) ||
            (a >= OFF_AUX_MAX_THR && a <= OFF_AUX_MIN_THR + 8'h01);
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] memFf [0:MEM_DEPTH-1];
  logic [7:0] nxtMem [0:MEM_DEPTH-1];
  logic [7:0] controlFf, nxtControl;
  logic [7:0] alertEnFf, nxtAlertEn;
  logic [7:0] statusFf, nxtStatus;
  logic [7:0] faultFf, nxtFault;
  logic [3:0] updFf, nxtUpd;
  logic [7:0] rdDataFf, nxtRdData;
  logic rdValidFf, nxtRdValid;
  logic alertFf, nxtAlert;
  logic testModeNow;
  logic [7:0] hits;

  assign testModeNow = controlFf[CTRL_TEST_MODE_BIT];

  // ************************************************************
  // Register writes and result capture
  // ************************************************************
  always_comb
  begin
    for (int i = 0; i < MEM_DEPTH; i++)
    begin
      nxtMem[i] = memFf[i];
    end
    nxtControl = controlFf;
    nxtAlertEn = alertEnFf;
    nxtUpd = 4'h0;
    if (regReq.wr)
    begin
      if (regReq.addr == OFF_CONTROL)
      begin
        nxtControl = regReq.wdata;
      end
      else if (regReq.addr == OFF_ALERT_EN)
      begin
        nxtAlertEn = regReq.wdata;
      end
      else if (isThr(regReq.addr) || (isMeas(regReq.addr) && testModeNow))
      begin
        nxtMem[regReq.addr[5:0]] = isLowByte(regReq.addr) ?
                                   (regReq.wdata & LOW_BYTE_KEEP) : regReq.wdata;
        if (isMeas(regReq.addr))
        begin
          if (regReq.addr <= OFF_POWER_MEAS + 8'h02)
            nxtUpd[Q_POWER] = 1'b1;
          else if (regReq.addr <= OFF_SENSE_MEAS + 8'h01)
            nxtUpd[Q_SENSE] = 1'b1;
          else if (regReq.addr <= OFF_VOLT_MEAS + 8'h01)
            nxtUpd[Q_VOLT] = 1'b1;
          else
            nxtUpd[Q_AUX] = 1'b1;
        end
      end
    end
    if (!testModeNow)
    begin
      if (powerResult.valid)
      begin
        nxtMem[OFF_POWER_MEAS[5:0]] = powerResult.data[23:16];
        nxtMem[OFF_POWER_MEAS[5:0] + 6'h01] = powerResult.data[15:8];
        nxtMem[OFF_POWER_MEAS[5:0] + 6'h02] = powerResult.data[7:0];
        nxtUpd[Q_POWER] = 1'b1;
      end
      if (senseResult.valid)
      begin
        nxtMem[OFF_SENSE_MEAS[5:0]] = senseResult.data[11:4];
        nxtMem[OFF_SENSE_MEAS[5:0] + 6'h01] = {senseResult.data[3:0], 4'h0};
        nxtUpd[Q_SENSE] = 1'b1;
      end
      if (inputVoltageChannel.valid)
      begin
        nxtMem[OFF_VOLT_MEAS[5:0]] = inputVoltageChannel.data[11:4];
        nxtMem[OFF_VOLT_MEAS[5:0] + 6'h01] = {inputVoltageChannel.data[3:0], 4'h0};
        nxtUpd[Q_VOLT] = 1'b1;
      end
      if (auxiliaryInput.valid)
      begin
        nxtMem[OFF_AUX_MEAS[5:0]] = auxiliaryInput.data[11:4];
        nxtMem[OFF_AUX_MEAS[5:0] + 6'h01] = {auxiliaryInput.data[3:0], 4'h0};
        nxtUpd[Q_AUX] = 1'b1;
      end
    end
  end

  // ************************************************************
  // Limit comparison, fault latching, alert and read data
  // ************************************************************
  always_comb
  begin
    nxtStatus = statusFf;
    if (updFf[Q_POWER])
      nxtStatus[7:6] = compare(
        {memFf[OFF_POWER_MEAS[5:0]], memFf[OFF_POWER_MEAS[5:0] + 6'h01],
         memFf[OFF_POWER_MEAS[5:0] + 6'h02]},
        {memFf[OFF_POWER_MAX_THR[5:0]], memFf[OFF_POWER_MAX_THR[5:0] + 6'h01],
         memFf[OFF_POWER_MAX_THR[5:0] + 6'h02]},
        {memFf[OFF_POWER_MIN_THR[5:0]], memFf[OFF_POWER_MIN_THR[5:0] + 6'h01],
         memFf[OFF_POWER_MIN_THR[5:0] + 6'h02]});
    if (updFf[Q_SENSE])
      nxtStatus[5:4] = compare(
        val12(memFf[OFF_SENSE_MEAS[5:0]], memFf[OFF_SENSE_MEAS[5:0] + 6'h01]),
        val12(memFf[OFF_SENSE_MAX_THR[5:0]], memFf[OFF_SENSE_MAX_THR[5:0] + 6'h01]),
        val12(memFf[OFF_SENSE_MIN_THR[5:0]], memFf[OFF_SENSE_MIN_THR[5:0] + 6'h01]));
    if (updFf[Q_VOLT])
      nxtStatus[3:2] = compare(
        val12(memFf[OFF_VOLT_MEAS[5:0]], memFf[OFF_VOLT_MEAS[5:0] + 6'h01]),
        val12(memFf[OFF_VOLT_MAX_THR[5:0]], memFf[OFF_VOLT_MAX_THR[5:0] + 6'h01]),
        val12(memFf[OFF_VOLT_MIN_THR[5:0]], memFf[OFF_VOLT_MIN_THR[5:0] + 6'h01]));
    if (updFf[Q_AUX])
      nxtStatus[1:0] = compare(
        val12(memFf[OFF_AUX_MEAS[5:0]], memFf[OFF_AUX_MEAS[5:0] + 6'h01]),
        val12(memFf[OFF_AUX_MAX_THR[5:0]], memFf[OFF_AUX_MAX_THR[5:0] + 6'h01]),
        val12(memFf[OFF_AUX_MIN_THR[5:0]], memFf[OFF_AUX_MIN_THR[5:0] + 6'h01]));
    hits = nxtStatus & {{2{updFf[Q_POWER]}}, {2{updFf[Q_SENSE]}},
                        {2{updFf[Q_VOLT]}}, {2{updFf[Q_AUX]}}};
    nxtFault = faultFf;
    if (regReq.wr && regReq.addr == OFF_FAULT)
      nxtFault = regReq.wdata;
    nxtFault = nxtFault | hits;
    nxtAlert = |(statusFf & alertEnFf);
    nxtRdValid = regReq.rd;
    nxtRdData = BYTE_RESET;
    if (regReq.rd)
    begin
      case (regReq.addr)
        OFF_CONTROL: nxtRdData = controlFf;
        OFF_ALERT_EN: nxtRdData = alertEnFf;
        OFF_STATUS: nxtRdData = statusFf;
        OFF_FAULT: nxtRdData = faultFf;
        default:
        begin
          if (regReq.addr >= OFF_POWER_MEAS && regReq.addr <= OFF_LAST)
            nxtRdData = memFf[regReq.addr[5:0]];
          else
            nxtRdData = BYTE_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < MEM_DEPTH; i++)
      begin
        memFf[i] <= BYTE_RESET;
      end
      controlFf <= CONTROL_RESET;
      alertEnFf <= ALERT_EN_RESET;
      statusFf <= BYTE_RESET;
      faultFf <= BYTE_RESET;
      updFf <= 4'h0;
      rdDataFf <= BYTE_RESET;
      rdValidFf <= 1'b0;
      alertFf <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < MEM_DEPTH; i++)
      begin
        memFf[i] <= nxtMem[i];
      end
      controlFf <= nxtControl;
      alertEnFf <= nxtAlertEn;
      statusFf <= nxtStatus;
      faultFf <= nxtFault;
      updFf <= nxtUpd;
      rdDataFf <= nxtRdData;
      rdValidFf <= nxtRdValid;
      alertFf <= nxtAlert;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rdData = rdDataFf;
  assign rdValid = rdValidFf;
  assign testMode = controlFf[CTRL_TEST_MODE_BIT];
  assign alert = alertFf;

endmodule

`default_nettype wire

// ### bench/limit_regs_monitor.sv
// Assertion checker for the limit status and fault bank
// Sees only the top module ports; attached by bind
`timescale 1ns/100ps
`default_nettype none
module limit_regs_monitor
  import limit_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire reg_req_s regReq,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire result_s powerResult,
  input wire result_s senseResult,
  input wire result_s inputVoltageChannel,
  input wire result_s auxiliaryInput,
  input wire logic testMode,
  input wire logic alert
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ev;
  logic ctl;
  assign ev = regReq.wr | powerResult.valid | senseResult.valid
    | inputVoltageChannel.valid | auxiliaryInput.valid;
  assign ctl = regReq.wr && regReq.addr == OFF_CONTROL;
  property p_rd_ans;
    regReq.rd |=> rdValid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_idle;
    !regReq.rd |=> !rdValid && rdData == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_tm_set;
    ctl |=> testMode == $past(regReq.wdata[CTRL_TEST_MODE_BIT]);
  endproperty
  a_tm_set: assert property (p_tm_set) else $error("test mode not written");
  property p_tm_hold;
    !ctl |=> $stable(testMode);
  endproperty
  a_tm_hold: assert property (p_tm_hold) else $error("test mode moved");
  property p_low_zero;
    regReq.rd && regReq.addr inside {8'h15, 8'h1b, 8'h1d, 8'h1f, 8'h25, 8'h27, 8'h29,
      8'h2f, 8'h31} |=> rdData[3:0] == 4'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("reserved bits set");
  property p_alert_off;
    (regReq.wr && regReq.addr == OFF_ALERT_EN && regReq.wdata == 8'h00)
      ##1 !(regReq.wr && regReq.addr == OFF_ALERT_EN) |=> !alert;
  endproperty
  a_alert_off: assert property (p_alert_off) else $error("alert while masked");
  property p_alert_rise;
    $rose(alert) |-> $past(ev, 2) || $past(ev, 3);
  endproperty
  a_alert_rise: assert property (p_alert_rise) else $error("alert rose alone");
  property p_alert_fall;
    $fell(alert) |-> $past(ev, 2) || $past(ev, 3);
  endproperty
  a_alert_fall: assert property (p_alert_fall) else $error("alert fell alone");
  c_read: cover property (regReq.rd ##1 rdValid);
  c_alert: cover property ($rose(alert));
  c_fault_wr: cover property (regReq.wr && regReq.addr == OFF_FAULT);
endmodule
`default_nettype wire

// ### bench/host_model.sv
// Host side register master of the limit bank
// One-cycle strobes; read data sampled the cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
module host_model
  import limit_regs_pkg::*;
(
  input wire logic clk,
  output var reg_req_s regReq,
  input wire logic [7:0] rdData
);
  initial regReq = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    @(negedge clk);
    d = rdData;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_limit_status_fault_regs.sv
// Self-checking bench of the limit status and fault bank
// Results driven here; register traffic through the host model
`timescale 1ns/100ps
`default_nettype none
module tb_limit_status_fault_regs import limit_regs_pkg::*;;
  logic clk, rst_n, testMode, alert, rdValid, tm;
  reg_req_s regReq;
  logic [7:0] rdData, st, flt, en;
  result_s res[4];
  int n_fail, check_count, q, v, m, c;
  int thrMax[4], thrMin[4], meas[4];
  int offs[4][3] = '{'{OFF_AUX_MEAS, OFF_AUX_MAX_THR, OFF_AUX_MIN_THR},
    '{OFF_VOLT_MEAS, OFF_VOLT_MAX_THR, OFF_VOLT_MIN_THR},
    '{OFF_SENSE_MEAS, OFF_SENSE_MAX_THR, OFF_SENSE_MIN_THR},
    '{OFF_POWER_MEAS, OFF_POWER_MAX_THR, OFF_POWER_MIN_THR}};
  limit_status_fault_regs limit_status_fault_regs_i (.clk, .rst_n, .regReq, .rdData,
    .rdValid, .powerResult(res[Q_POWER]), .senseResult(res[Q_SENSE]),
    .inputVoltageChannel(res[Q_VOLT]), .auxiliaryInput(res[Q_AUX]), .testMode, .alert);
  host_model host_model_i (.clk, .regReq, .rdData);
  // ************************************************************
  // Model and tasks
  // ************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input int a, input logic [7:0] exp);
    logic [7:0] d;
    host_model_i.rd(8'(a), d);
    chk(d, exp);
  endtask
  task automatic cmp(input int k);
    st[2*k+1] = meas[k] > thrMax[k];
    st[2*k] = meas[k] < thrMin[k];
    flt = flt | (st & (8'h03 << (2 * k)));
  endtask
  task automatic wv(input int k, input int f, input int x, input bit rb);
    int n, s, w, b, p;
    n = k == Q_POWER ? 3 : 2;
    s = k == Q_POWER ? 0 : 4;
    for (int i = 0; i < n; i++)
    begin
      p = 8 * (n - 1 - i);
      b = ((x << s) >> p) & 255;
      if (rb)
        rdc(offs[k][f] + i, 8'(b));
      else
        host_model_i.wr(8'(offs[k][f] + i), 8'(b));
      if (!rb && f == 0 && tm)
      begin
        w = (meas[k] << s) & ~(255 << p) | (b << p);
        meas[k] = w >> s;
        cmp(k);
      end
    end
    if (!rb && f == 1) thrMax[k] = x;
    if (!rb && f == 2) thrMin[k] = x;
  endtask
  task automatic pulse(input int k, input int x);
    @(posedge clk);
    res[k] <= '{valid: 1'b1, data: 24'(x)};
    @(posedge clk);
    res[k] <= '{valid: 1'b0, data: ~24'(x)};
    repeat (2) @(posedge clk);
    if (!tm)
    begin
      meas[k] = x;
      cmp(k);
    end
    @(negedge clk);
    chk(8'(alert), 8'(|(st & en)));
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ************************************************************
  // Clock, watchdog and tests
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #2000000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    {n_fail, check_count, st, flt, tm, en} = '0;
    foreach (res[i]) res[i] = '0;
    void'($urandom(32'h163e));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc(OFF_CONTROL, CONTROL_RESET);
    rdc(OFF_ALERT_EN, ALERT_EN_RESET);
    rdc(OFF_FAULT, 8'h00);
    en = 8'($urandom);
    host_model_i.wr(OFF_ALERT_EN, en);
    for (int k = 0; k < 4; k++)
    begin
      m = k == Q_POWER ? 24 : 12;
      v = 1 + $urandom % (1 << (m - 1));
      wv(k, 2, v, 0);
      wv(k, 1, v + $urandom % (1 << (m - 1)), 0);
      wv(k, 1, thrMax[k], 1);
      wv(k, 2, thrMin[k], 1);
    end
    repeat (24)
    begin
      q = $urandom % 4;
      c = $urandom % 5;
      m = q == Q_POWER ? 24 : 12;
      v = c == 0 ? thrMax[q] : c == 1 ? thrMax[q] + 1 : c == 2 ? thrMin[q]
        : c == 3 ? thrMin[q] - 1 : $urandom;
      v = v & ((1 << m) - 1);
      pulse(q, v);
      rdc(OFF_STATUS, st);
      rdc(OFF_FAULT, flt);
      wv(q, 0, v, 1);
    end
    host_model_i.wr(OFF_STATUS, ~st);
    rdc(OFF_STATUS, st);
    host_model_i.wr(OFF_FAULT, 8'h00);
    flt = 8'h00;
    rdc(OFF_FAULT, flt);
    wv(Q_SENSE, 0, meas[Q_SENSE] ^ 12'h5a5, 0);
    wv(Q_SENSE, 0, meas[Q_SENSE], 1);
    host_model_i.wr(OFF_CONTROL, CONTROL_RESET | 8'h10);
    tm = 1'b1;
    @(negedge clk);
    chk(8'(testMode), 8'h01);
    pulse(Q_VOLT, (thrMax[Q_VOLT] + 1) & 12'hfff);
    rdc(OFF_STATUS, st);
    wv(Q_AUX, 0, (thrMax[Q_AUX] + 1) & 12'hfff, 0);
    wv(Q_POWER, 0, thrMin[Q_POWER] - 1, 0);
    rdc(OFF_STATUS, st);
    rdc(OFF_FAULT, flt);
    host_model_i.wr(OFF_FAULT, 8'ha5);
    flt = 8'ha5;
    rdc(OFF_FAULT, flt);
    host_model_i.wr(OFF_ALERT_EN, 8'h00);
    en = 8'h00;
    rdc(8'h40, 8'h00);
    chk(8'(alert), 8'h00);
    end_of_test();
  end
endmodule
bind limit_status_fault_regs limit_regs_monitor limit_regs_monitor_i (.clk, .rst_n,
  .regReq, .rdData, .rdValid, .powerResult, .senseResult, .inputVoltageChannel,
  .auxiliaryInput, .testMode, .alert);
`default_nettype wire
